/* src/gp3_defs.svh */
// Register indices, field positions, reset values and bus codes of port 3
`ifndef GP3_DEFS_SVH
`define GP3_DEFS_SVH
// Register indices; the byte address is four times the index
`define GP3_IDX_MODE    16'hffca
`define GP3_IDX_DATA    16'hffd6
`define GP3_IDX_PULL    16'hffe1
`define GP3_IDX_DIR     16'hffe6
`define GP3_IDX_SCTL    16'hffa8
`define GP3_ADDR_HI     14'h0000
// Reset values
`define GP3_RST_DATA    8'h00
`define GP3_RST_DIR     8'h00
`define GP3_RST_PULL    8'h00
`define GP3_RST_MODE    3'h0
`define GP3_RST_CKS     1'b0
// Mode bits; each bit number is also the pin it switches
`define GP3_MODE_SCK    0
`define GP3_MODE_SI     1
`define GP3_MODE_SO     2
// Clock source bit inside the serial control register
`define GP3_SCTL_CKS    3
// Read value of the write-only direction register
`define GP3_DIR_READ    8'hff
// Bus response codes
`define GP3_RESP_OKAY   2'h0
`define GP3_RESP_DECERR 2'h3
`endif

/* src/gp3_pkg.sv */
// Types shared by the port 3 block
package gp3_pkg;
    // Register selected by an address
    typedef enum logic [2:0] {
        gp3_sel_none, gp3_sel_mode, gp3_sel_data, gp3_sel_pull, gp3_sel_dir, gp3_sel_sctl
    } gp3_sel_e;
    // One register access from the bus slave
    typedef struct packed {
        logic        go;
        logic [31:0] addr;
        logic [7:0]  data;
        logic        strb;
    } gp3_acc_s;
    // Bus slave state
    typedef struct packed {
        logic        aw_held, awready, w_held, wready;
        logic [31:0] aw_addr;
        logic [7:0]  w_data;
        logic        w_strb, bvalid, arready, rvalid;
        logic [1:0]  bresp, rresp;
        logic [7:0]  rdata;
    } gp3_bus_s;
    // Pin synchroniser state
    typedef struct packed {
        logic [7:0] s1, s2, s3, lvl;
    } gp3_sync_s;
    // Port state
    typedef struct packed {
        logic [7:0] data, dir, pull;
        logic [2:0] mode;
        logic       cks;
        logic [7:0] pin_out, pin_oe, pull_en;
        logic       rxd, sck_in, sck_src;
    } gp3_port_s;
endpackage

/* src/gp3_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
module gp3_pin_sync
(
    input  wire logic       clock,  // System clock
    input  wire logic       rst,    // Synchronous reset, high
    input  wire logic [7:0] pin_in, // Raw pin levels
    output wire logic [7:0] lvl     // Filtered pin levels
);
    import gp3_pkg::*;
    gp3_sync_s r, n;
    // Stage chain; a level counts once stages two and three agree
    always_comb
    begin
        n     = r;
        n.s1  = pin_in;
        n.s2  = r.s1;
        n.s3  = r.s2;
        n.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 ^ r.s3));
    end
    always_ff @(posedge clock)
    begin
        if (rst)
            r <= '0;
        else
            r <= n;
    end
    assign lvl = r.lvl;
    sync_agree_a: assert property (@(posedge clock) disable iff (rst)
        ##1 (((r.lvl ^ $past(r.lvl)) & $past(r.s2 ^ r.s3)) == 8'h00))
        else $error("pin level moved while stages disagreed");
endmodule // gp3_pin_sync

/* src/gp3_axil_slave.sv */
// AXI4-Lite slave that turns bus transfers into register accesses
`include "gp3_defs.svh"

module gp3_axil_slave
(
    input  wire logic             clock,   // System clock
    input  wire logic             rst,     // Synchronous reset, high
    input  wire logic             awvalid, // Write address valid
    output wire logic             awready, // Write address ready
    input  wire logic [31:0]      awaddr,  // Write address
    input  wire logic             wvalid,  // Write data valid
    output wire logic             wready,  // Write data ready
    input  wire logic [31:0]      wdata,   // Write data
    input  wire logic [3:0]       wstrb,   // Write byte strobes
    output wire logic             bvalid,  // Write response valid
    input  wire logic             bready,  // Write response ready
    output wire logic [1:0]       bresp,   // Write response
    input  wire logic             arvalid, // Read address valid
    output wire logic             arready, // Read address ready
    input  wire logic [31:0]      araddr,  // Read address
    output wire logic             rvalid,  // Read data valid
    input  wire logic             rready,  // Read data ready
    output wire logic [31:0]      rdata,   // Read data
    output wire logic [1:0]       rresp,   // Read response
    output gp3_pkg::gp3_acc_s     wr_acc,  // Register write
    input  wire logic             wr_hit,  // Write address mapped
    output gp3_pkg::gp3_acc_s     rd_acc,  // Register read
    input  wire logic             rd_hit,  // Read address mapped
    input  wire logic [7:0]       rd_data  // Register read value
);
    import gp3_pkg::*;
    gp3_bus_s r, n;
    // Write fires once address and data are both held
    assign wr_acc = '{go: r.aw_held && r.w_held && !r.bvalid, addr: r.aw_addr,
                      data: r.w_data, strb: r.w_strb};
    assign rd_acc = '{go: arvalid && r.arready, addr: araddr, data: 8'h00, strb: 1'b0};
    // Channel handshakes
    always_comb
    begin
        n = r;
        if (awvalid && r.awready)
        begin
            n.aw_held = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid && r.wready)
        begin
            n.w_held = 1'b1;
            n.w_data = wdata[7:0];
            n.w_strb = wstrb[0];
        end
        if (r.bvalid && bready)
            n.bvalid = 1'b0;
        if (wr_acc.go)
        begin
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = wr_hit ? `GP3_RESP_OKAY : `GP3_RESP_DECERR;
        end
        n.awready = !n.aw_held && !n.bvalid;
        n.wready  = !n.w_held && !n.bvalid;
        if (r.rvalid && rready)
            n.rvalid = 1'b0;
        if (rd_acc.go)
        begin
            n.rvalid = 1'b1;
            n.rdata  = rd_hit ? rd_data : 8'h00;
            n.rresp  = rd_hit ? `GP3_RESP_OKAY : `GP3_RESP_DECERR;
        end
        n.arready = !n.rvalid;
    end
    always_ff @(posedge clock)
    begin
        if (rst)
            r <= '0;
        else
            r <= n;
    end
    assign awready = r.awready;
    assign wready  = r.wready;
    assign bvalid  = r.bvalid;
    assign bresp   = r.bresp;
    assign arready = r.arready;
    assign rvalid  = r.rvalid;
    assign rdata   = {24'h000000, r.rdata};
    assign rresp   = r.rresp;
endmodule // gp3_axil_slave

/* src/gp3_port.sv */
// Port 3: eight-pin I/O port with serial pin multiplexing and AXI4-Lite registers
// Contract
// - Eight pins, each input or output
// - Output pins read back stored data
// - Input pins read back pin level
// - Data register resets to zero
// - Direction one drives, zero releases pin
// - Direction and data act only in I/O mode; on serial pins direction still gates pull-up and selects data read-back
// - Direction register reads as all ones
// - Direction register resets to zero
// - Pull-up on only for input with enable
// - Pull-up off when cleared or output
// - Pull-up register resets zero, read/write
// - Mode register resets to zero
// - Mode bit 2 gives pin 2 to transmit
// - Mode bit 1 gives pin 1 to receive
// - Mode bit 0 gives pin 0 to clock
// - Clock source zero drives, one accepts clock
//
// The AXI4-Lite interface to the registers was left to the implementer.
`include "gp3_defs.svh"

module gp3_port
(
    input  wire logic        clock,       // System clock, 50 MHz
    input  wire logic        rst,         // Synchronous reset, high
    input  wire logic        awvalid,     // Write address valid
    output wire logic        awready,     // Write address ready
    input  wire logic [31:0] awaddr,      // Write address
    input  wire logic        wvalid,      // Write data valid
    output wire logic        wready,      // Write data ready
    input  wire logic [31:0] wdata,       // Write data
    input  wire logic [3:0]  wstrb,       // Write byte strobes
    output wire logic        bvalid,      // Write response valid
    input  wire logic        bready,      // Write response ready
    output wire logic [1:0]  bresp,       // Write response
    input  wire logic        arvalid,     // Read address valid
    output wire logic        arready,     // Read address ready
    input  wire logic [31:0] araddr,      // Read address
    output wire logic        rvalid,      // Read data valid
    input  wire logic        rready,      // Read data ready
    output wire logic [31:0] rdata,       // Read data
    output wire logic [1:0]  rresp,       // Read response
    input  wire logic [7:0]  pin_in,      // Pin levels seen at the pads
    output wire logic [7:0]  pin_out,     // Pin drive values
    output wire logic [7:0]  pin_oe,      // Pin drive enables, high drives
    output wire logic [7:0]  pullup_en,   // Pull-up enables, high on
    input  wire logic        ser_txd,     // Serial transmit data
    input  wire logic        ser_sck_out, // Serial clock to drive out
    output wire logic        ser_rxd,     // Serial receive data
    output wire logic        ser_sck_in,  // External serial clock
    output wire logic        ser_sck_src  // Serial clock source select
);
    import gp3_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    gp3_port_s  r;
    gp3_port_s  n;
    gp3_acc_s   wr_acc;
    gp3_acc_s   rd_acc;
    gp3_sel_e   wr_sel;
    gp3_sel_e   rd_sel;
    logic [7:0] lvl;
    logic [7:0] rd_port;
    logic [7:0] rd_data;
    logic [7:0] gp_oe;
    logic [7:0] gp_out;
    logic [7:0] gp_pull;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Maps a byte address to a register, none when unmapped
    function automatic gp3_sel_e reg_sel(input logic [31:0] addr);
        gp3_sel_e s;
        s = gp3_sel_none;
        if (addr == {`GP3_ADDR_HI, `GP3_IDX_MODE, 2'b00})
            s = gp3_sel_mode;
        if (addr == {`GP3_ADDR_HI, `GP3_IDX_DATA, 2'b00})
            s = gp3_sel_data;
        if (addr == {`GP3_ADDR_HI, `GP3_IDX_PULL, 2'b00})
            s = gp3_sel_pull;
        if (addr == {`GP3_ADDR_HI, `GP3_IDX_DIR, 2'b00})
            s = gp3_sel_dir;
        if (addr == {`GP3_ADDR_HI, `GP3_IDX_SCTL, 2'b00})
            s = gp3_sel_sctl;
        return s;
    endfunction

    assign wr_sel = reg_sel(wr_acc.addr);
    assign rd_sel = reg_sel(rd_acc.addr);

    // ------------------------------------------------------------
    // Bus slave and pin synchroniser
    // ------------------------------------------------------------
    gp3_axil_slave u_bus
    (
        .clock   (clock),
        .rst     (rst),
        .awvalid (awvalid),
        .awready (awready),
        .awaddr  (awaddr),
        .wvalid  (wvalid),
        .wready  (wready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .bvalid  (bvalid),
        .bready  (bready),
        .bresp   (bresp),
        .arvalid (arvalid),
        .arready (arready),
        .araddr  (araddr),
        .rvalid  (rvalid),
        .rready  (rready),
        .rdata   (rdata),
        .rresp   (rresp),
        .wr_acc  (wr_acc),
        .wr_hit  (wr_sel != gp3_sel_none),
        .rd_acc  (rd_acc),
        .rd_hit  (rd_sel != gp3_sel_none),
        .rd_data (rd_data)
    );

    gp3_pin_sync u_sync
    (
        .clock  (clock),
        .rst    (rst),
        .pin_in (pin_in),
        .lvl    (lvl)
    );

    // ------------------------------------------------------------
    // Per-pin general I/O logic
    // ------------------------------------------------------------
    // Drive, pull-up and read-back of each pin in general I/O use
    for (genvar i = 0; i < 8; i++)
    begin : g_pin
        assign gp_oe[i]   = r.dir[i];
        assign gp_out[i]  = r.data[i];
        assign gp_pull[i] = !r.dir[i] && r.pull[i];
        assign rd_port[i] = r.dir[i] ? r.data[i] : lvl[i];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Register writes, read mux and pin multiplexer
    always_comb
    begin
        n = r;
        if (wr_acc.go && wr_acc.strb)
        begin
            case (wr_sel)
                gp3_sel_data: n.data = wr_acc.data;
                gp3_sel_dir:  n.dir  = wr_acc.data;
                gp3_sel_pull: n.pull = wr_acc.data;
                gp3_sel_mode: n.mode = wr_acc.data[2:0];
                gp3_sel_sctl: n.cks  = wr_acc.data[`GP3_SCTL_CKS];
                default:      n.cks  = r.cks;
            endcase
        end

        // Read value of the addressed register
        rd_data = 8'h00;
        case (rd_sel)
            gp3_sel_data: rd_data = rd_port;
            gp3_sel_dir:  rd_data = `GP3_DIR_READ;
            gp3_sel_pull: rd_data = r.pull;
            gp3_sel_mode: rd_data = {5'h00, r.mode};
            gp3_sel_sctl: rd_data[`GP3_SCTL_CKS] = r.cks;
            default:      rd_data = 8'h00;
        endcase

        // General I/O first, then serial functions take their pins
        n.pin_oe  = gp_oe;
        n.pin_out = gp_out;
        n.pull_en = gp_pull;
        if (r.mode[`GP3_MODE_SO])
        begin
            n.pin_oe[`GP3_MODE_SO]  = 1'b1;
            n.pin_out[`GP3_MODE_SO] = ser_txd;
        end
        if (r.mode[`GP3_MODE_SI])
        begin
            n.pin_oe[`GP3_MODE_SI]  = 1'b0;
            n.pin_out[`GP3_MODE_SI] = 1'b0;
        end
        if (r.mode[`GP3_MODE_SCK])
        begin
            n.pin_oe[`GP3_MODE_SCK]  = !r.cks;
            n.pin_out[`GP3_MODE_SCK] = r.cks ? 1'b0 : ser_sck_out;
        end

        // Serial inputs; receive idles high when its pin is not selected
        n.rxd     = r.mode[`GP3_MODE_SI] ? lvl[`GP3_MODE_SI] : 1'b1;
        n.sck_in  = (r.mode[`GP3_MODE_SCK] && r.cks) ? lvl[`GP3_MODE_SCK] : 1'b0;
        n.sck_src = r.cks;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset clears every control register and releases all pins
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            r         <= '0;
            r.data    <= `GP3_RST_DATA;
            r.dir     <= `GP3_RST_DIR;
            r.pull    <= `GP3_RST_PULL;
            r.mode    <= `GP3_RST_MODE;
            r.cks     <= `GP3_RST_CKS;
            r.rxd     <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pins and serial signals straight from the state register
    assign pin_out     = r.pin_out;
    assign pin_oe      = r.pin_oe;
    assign pullup_en   = r.pull_en;
    assign ser_rxd     = r.rxd;
    assign ser_sck_in  = r.sck_in;
    assign ser_sck_src = r.sck_src;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // A direction write taken by the register file
    sequence dir_wr_s;
        wr_acc.go && wr_acc.strb && wr_sel == gp3_sel_dir;
    endsequence

    // A read of the data register taken by the bus
    sequence data_rd_s;
        rd_acc.go && rd_sel == gp3_sel_data;
    endsequence

    // A read of the direction register taken by the bus
    sequence dir_rd_s;
        rd_acc.go && rd_sel == gp3_sel_dir;
    endsequence

    // Direction write reaches the upper pin drivers two cycles on
    property dir_drive_p;
        dir_wr_s |-> ##2 (pin_oe[7:3] == $past(wr_acc.data[7:3], 2));
    endproperty

    // Data read mixes stored bits and synchronised pin levels
    property data_read_p;
        data_rd_s |=> rvalid && rdata[7:0] ==
            (($past(r.dir) & $past(r.data)) | (~$past(r.dir) & $past(lvl)));
    endproperty

    dir_drive_a: assert property (dir_drive_p)
        else $error("pin drive did not follow direction write");

    port_read_a: assert property (data_read_p)
        else $error("data read returned wrong mix of latch and pins");

    dir_read_a: assert property (dir_rd_s |=> rvalid && rdata[7:0] == 8'hff)
        else $error("direction register did not read as ones");

    reset_clear_a: assert property (disable iff (1'b0)
        $past(rst) |-> (r.data == 8'h00 && r.dir == 8'h00 && r.pull == 8'h00
                        && r.mode == 3'h0 && pin_oe == 8'h00))
        else $error("registers not cleared by reset");

    gpio_mode_a: assert property (r.mode == 3'h0 |=>
        pin_oe == $past(r.dir) && pin_out == $past(r.data))
        else $error("general I/O pins do not follow direction and data");

    pull_gate_a: assert property (##1 pullup_en == ($past(r.pull) & ~$past(r.dir)))
        else $error("pull-up enable wrong for direction and control");

    tx_pin_a: assert property (r.mode[2] |=>
        pin_oe[2] && pin_out[2] == $past(ser_txd))
        else $error("transmit pin not driven by serial data");

    rx_pin_a: assert property (r.mode[1] |=>
        !pin_oe[1] && ser_rxd == $past(lvl[1]))
        else $error("receive pin not routed to serial input");

    sck_out_a: assert property (r.mode[0] && !r.cks |=>
        pin_oe[0] && pin_out[0] == $past(ser_sck_out))
        else $error("clock pin not driving internal clock");

    sck_in_a: assert property (r.mode[0] && r.cks |=>
        !pin_oe[0] && ser_sck_in == $past(lvl[0]))
        else $error("clock pin not accepting external clock");

    // A read of the pull-up control register taken by the bus
    sequence pull_rd_s;
        rd_acc.go && rd_sel == gp3_sel_pull;
    endsequence

    // A pull-up control write taken by the register file
    sequence pull_wr_s;
        wr_acc.go && wr_acc.strb && wr_sel == gp3_sel_pull;
    endsequence

    // Pull-up control stores the written byte
    pull_store_a: assert property (pull_wr_s |=> r.pull == $past(wr_acc.data))
        else $error("pull-up control write not stored");

    // Pull-up control reads back the stored byte
    pull_read_a: assert property (pull_rd_s |=>
        rvalid && rdata[7:0] == $past(r.pull))
        else $error("pull-up control read value wrong");

    // Direction write lands in the stored direction byte
    dir_store_a: assert property (dir_wr_s |=> r.dir == $past(wr_acc.data))
        else $error("direction write not stored");

    // Pins seven to three never leave general I/O
    upper_pins_a: assert property (##1 pin_oe[7:3] == $past(r.dir[7:3])
        && pin_out[7:3] == $past(r.data[7:3]))
        else $error("upper pins do not follow direction and data");

    // Receive input idles high while its pin is general I/O
    rx_idle_a: assert property (!r.mode[1] |=> ser_rxd)
        else $error("receive input not idle high");

    // External clock input stays low unless selected
    sck_idle_a: assert property (!(r.mode[0] && r.cks) |=> !ser_sck_in)
        else $error("external clock input not held low");

    // Clock source select follows the stored bit
    sck_src_a: assert property (##1 ser_sck_src == $past(r.cks))
        else $error("clock source select not forwarded");

endmodule // gp3_port

/* sim/gp3_pad_model.sv */
// Model of the external circuitry on the eight port pins
module gp3_pad_model
(
    input  wire logic       clock,     // System clock
    input  wire logic [7:0] pin_out,   // Block drive values
    input  wire logic [7:0] pin_oe,    // Block drive enables
    input  wire logic [7:0] pullup_en, // Block pull-up enables
    input  wire logic [7:0] ext_oe,    // Outside driver enables
    input  wire logic [7:0] ext_val,   // Outside driver values
    output logic      [7:0] pin_in     // Resolved pad levels
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_reg = 8'h55;

    // Undriven pads without pull-up wander every cycle
    always_ff @(posedge clock)
        float_reg <= ~float_reg;

    // Block driver wins, then outside driver, then pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                  | (~pin_oe & ~ext_oe & (pullup_en | float_reg));
endmodule // gp3_pad_model

/* sim/gp3_port_tb.sv */
// Self-checking bench for the port 3 block
`include "gp3_defs.svh"
module gp3_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  pin_in, pin_out, pin_oe, pullup_en, d, v, p, e;
    logic [7:0]  ext_oe = 8'h00, ext_val = 8'h00;
    logic        ser_txd = 1'b0, ser_sck_out = 1'b0, ser_rxd, ser_sck_in, ser_sck_src;
    logic [33:0] exp_q[$];
    logic [1:0]  exp_b[$];
    int          mismatches = 0;
    int          total_checks = 0;

    always #10 clock = ~clock;

    gp3_port dut_u (.clock(clock), .rst(rst), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ser_txd(ser_txd), .ser_sck_out(ser_sck_out),
        .ser_rxd(ser_rxd), .ser_sck_in(ser_sck_in), .ser_sck_src(ser_sck_src));

    gp3_pad_model pad_u (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_oe(ext_oe), .ext_val(ext_val), .pin_in(pin_in));

    // Compare and count
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        total_checks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish();
        if (exp_q.size() + exp_b.size() > 0)
            mismatches++;
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Give up on a hung handshake
    task automatic stall();
        mismatches++;
        tally_and_finish();
    endtask

    // Bus write of one register word, response code checked
    task automatic axw(input logic [15:0] idx, input logic [7:0] dv, input logic [1:0] er);
        int   n;
        logic ad, wd, ta, tw;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        exp_b.push_back(er);
        awvalid <= 1'b1;
        awaddr <= {14'h0000, idx, 2'h0};
        wvalid <= 1'b1;
        wdata <= {24'h000000, dv};
        wstrb <= 4'hf;
        bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(negedge clock);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            ad = ad | ta;
            wd = wd | tw;
            n++;
            if (n > 50) stall();
        end
        ta = 1'b0;
        while (!ta)
        begin
            @(negedge clock);
            ta = bvalid;
            @(posedge clock);
            n++;
            if (n > 100) stall();
        end
        bready <= 1'b0;
        @(posedge clock);
    endtask

    // Bus read; expected word noted for the watcher
    task automatic axr(input logic [15:0] idx, input logic [7:0] dv, input logic [1:0] er);
        int   n;
        logic ta;
        n = 0;
        exp_q.push_back({er, 24'h000000, dv});
        arvalid <= 1'b1;
        araddr <= {14'h0000, idx, 2'h0};
        rready <= 1'b1;
        ta = 1'b0;
        while (!ta)
        begin
            @(negedge clock);
            ta = arready;
            @(posedge clock);
            if (ta) arvalid <= 1'b0;
            n++;
            if (n > 50) stall();
        end
        ta = 1'b0;
        while (!ta)
        begin
            @(negedge clock);
            ta = rvalid;
            @(posedge clock);
            n++;
            if (n > 100) stall();
        end
        rready <= 1'b0;
        @(posedge clock);
    endtask

    // Watcher: each read answer against the oldest note
    always @(negedge clock)
        if (rvalid && rready)
            check({rresp, rdata}, (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3ffffffff);

    // Watcher: each write response against the oldest note
    always @(negedge clock)
        if (bvalid && bready)
            check({32'h0, bresp}, {32'h0, (exp_b.size() > 0) ? exp_b.pop_front() : 2'h1});

    initial
    begin
        void'($urandom(96543));
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        ext_oe <= 8'hff;
        ext_val <= 8'h5a;
        repeat (10) @(posedge clock);
        check({26'h0, pin_oe}, 34'h0);
        check({26'h0, pullup_en}, 34'h0);
        axr(`GP3_IDX_DATA, 8'h5a, 2'h0);
        axr(`GP3_IDX_PULL, 8'h00, 2'h0);
        axr(`GP3_IDX_MODE, 8'h00, 2'h0);
        axr(`GP3_IDX_DIR, 8'hff, 2'h0);
        ext_oe <= 8'h00;
        axw(`GP3_IDX_DIR, 8'hff, 2'h0);
        axr(`GP3_IDX_DATA, 8'h00, 2'h0);
        // Random direction, data, pull-up and outside levels
        for (int k = 0; k < 6; k++)
        begin
            d = 8'($urandom);
            v = 8'($urandom);
            p = 8'($urandom);
            e = 8'($urandom);
            ext_oe <= ~d;
            ext_val <= e;
            axw(`GP3_IDX_DIR, d, 2'h0);
            axw(`GP3_IDX_DATA, v, 2'h0);
            axw(`GP3_IDX_PULL, p, 2'h0);
            repeat (8) @(posedge clock);
            check({26'h0, pin_oe}, {26'h0, d});
            check({26'h0, pin_out & d}, {26'h0, v & d});
            check({26'h0, pullup_en}, {26'h0, p & ~d});
            axr(`GP3_IDX_DATA, (v & d) | (e & ~d), 2'h0);
            axr(`GP3_IDX_PULL, p, 2'h0);
            axr(`GP3_IDX_DIR, 8'hff, 2'h0);
        end
        // Serial functions on the three low pins
        axw(`GP3_IDX_DIR, 8'hfb, 2'h0);
        axw(`GP3_IDX_DATA, 8'h00, 2'h0);
        ext_oe <= 8'h02;
        axw(`GP3_IDX_MODE, 8'h07, 2'h0);
        axr(`GP3_IDX_MODE, 8'h07, 2'h0);
        for (int k = 0; k < 4; k++)
        begin
            ser_txd <= k[0];
            ser_sck_out <= k[1];
            ext_val <= 8'(k);
            repeat (8) @(posedge clock);
            check({32'h0, pin_oe[2:1]}, {32'h0, 2'b10});
            check({32'h0, pin_out[2], ser_rxd}, {32'h0, k[0], k[1]});
            check({32'h0, pin_oe[0], pin_out[0]}, {32'h0, 1'b1, k[1]});
            axr(`GP3_IDX_DATA, {5'h00, k[0], 2'b00}, 2'h0);
        end
        ext_oe <= 8'h03;
        axw(`GP3_IDX_SCTL, 8'h08, 2'h0);
        for (int k = 0; k < 2; k++)
        begin
            ext_val <= 8'(k + 1);
            repeat (8) @(posedge clock);
            check({31'h0, pin_oe[0], ser_sck_in, ser_sck_src}, {31'h0, 1'b0, ~k[0], 1'b1});
        end
        // Unmapped place
        axw(16'h0004, 8'h55, 2'h3);
        axr(16'h0004, 8'h00, 2'h3);
        // Reset in mid-run clears what was set
        axw(`GP3_IDX_DATA, 8'hc3, 2'h0);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        check({26'h0, pin_oe | pullup_en}, 34'h0);
        axr(`GP3_IDX_MODE, 8'h00, 2'h0);
        axr(`GP3_IDX_PULL, 8'h00, 2'h0);
        axw(`GP3_IDX_DIR, 8'hff, 2'h0);
        axr(`GP3_IDX_DATA, 8'h00, 2'h0);
        tally_and_finish();
    end
endmodule // gp3_port_tb
